// *** design/spmc_pkg.sv ***
// Package with modes, register fields and timing constants of the sleep controller.
// Operation
// - Sleep needs enable bit plus sleep instruction.
// - Idle mode stops only CPU and flash clocks.
// - Any enabled interrupt wakes from idle.
// - Noise mode stops I/O, CPU, flash clocks.
// - Noise mode wakes only on listed sources.
// - Enabled converter starts conversion on entry.
// - Power-down stops oscillator and all clocks.
// - Power-down wakes only on asynchronous sources.
// - Power-down wake waits fuse-selected start-up.
// - Power-save keeps timer 2, wakes on it.
// - Power-save gates oscillators by timer 2 clocking.
// - Standby is power-down with oscillator, six cycles.
// - Extended standby is power-save with oscillator.
// - Interrupt wake halts four extra cycles.
// - Register file and RAM preserved in sleep.
// - Reset during sleep wakes to reset vector.
// - Brown-out off in deep sleep if requested.
// - Brown-out sleep lengthens wake to 60 us.
// - Brown-out sleep-off bit 6, reset zero.
// - Timed unlock sequence sets sleep-off bit.
// - Power-reduction bit stops and freezes peripheral.
// - Power reduction matters in active and idle.
package spmc_pkg;
  typedef enum logic [2:0] {
    SPMC_IDLE = 3'b000,
    SPMC_NOISE = 3'b001,
    SPMC_PDOWN = 3'b010,
    SPMC_PSAVE = 3'b011,
    SPMC_RSV4 = 3'b100,
    SPMC_RSV5 = 3'b101,
    SPMC_STBY = 3'b110,
    SPMC_XSTBY = 3'b111
  } spmc_mode_e;
  typedef enum logic [1:0] {
    SPMC_RUN = 2'b00,
    SPMC_SLEEP = 2'b01,
    SPMC_WAKE = 2'b10
  } spmc_state_e;
  localparam int SPMC_BROWNOUT_SLEEP_OFF_BIT = 6;
  localparam int SPMC_BROWNOUT_SLEEP_UNLOCK_BIT = 5;
  localparam logic [7:0] SPMC_CORE_CTRL_RESET = 8'h00;
  localparam int SPMC_UNLOCK_WINDOW = 4;
  localparam int SPMC_BROWNOUT_SLEEP_OFF_DELAY = 3;
  localparam int SPMC_BROWNOUT_SLEEP_OFF_HOLD = 3;
  localparam int SPMC_IRQ_HALT = 4;
  localparam int SPMC_STBY_WAKE = 6;
  localparam int SPMC_CLK_MHZ = 10;
  localparam int SPMC_BOD_WAKE_US = 60;
  localparam int SPMC_BOD_WAKE_CYC = SPMC_BOD_WAKE_US * SPMC_CLK_MHZ;
  localparam int SPMC_CNT_W = 16;
  localparam int SPMC_NPER = 8;
endpackage

// *** design/spmc_brownout_sleep_off_seq.sv ***
// Timed unlock sequence for the brown-out sleep-off bit.
`timescale 1ns/10ps
module spmc_brownout_sleep_off_seq
  import spmc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic wr_brownout_sleep_off,
  input wire logic wr_brownout_sleep_unlock,
  output logic brownout_sleep_off_active,
  output logic brownout_sleep_unlock_q
);
  logic [2:0] win_q, win_d;
  logic [2:0] dly_q, dly_d;
  logic [2:0] hold_q, hold_d;
  logic brownout_sleep_unlock_d;

  always_comb
  begin
    win_d = (win_q != 3'h0) ? win_q - 3'h1 : 3'h0;
    dly_d = (dly_q != 3'h0) ? dly_q - 3'h1 : 3'h0;
    hold_d = (hold_q != 3'h0) ? hold_q - 3'h1 : 3'h0;
    if (dly_q == 3'h1)
      hold_d = 3'(SPMC_BROWNOUT_SLEEP_OFF_HOLD);
    if (wr_en && wr_brownout_sleep_off && wr_brownout_sleep_unlock)
      win_d = 3'(SPMC_UNLOCK_WINDOW);
    else if (wr_en && wr_brownout_sleep_off && !wr_brownout_sleep_unlock && win_q != 3'h0)
    begin
      win_d = 3'h0;
      dly_d = 3'(SPMC_BROWNOUT_SLEEP_OFF_DELAY);
    end
    brownout_sleep_unlock_d = (win_d != 3'h0);
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      win_q <= 3'h0;
      dly_q <= 3'h0;
      hold_q <= 3'h0;
      brownout_sleep_unlock_q <= 1'b0;
    end
    else
    begin
      win_q <= win_d;
      dly_q <= dly_d;
      hold_q <= hold_d;
      brownout_sleep_unlock_q <= brownout_sleep_unlock_d;
    end
  end

  assign brownout_sleep_off_active = (hold_q != 3'h0);

  a_brownout_sleep_off_late: assert property (@(posedge clock) disable iff (rst)
    (wr_en && wr_brownout_sleep_off && !wr_brownout_sleep_unlock && win_q != 3'h0) |=> !brownout_sleep_off_active[*3] ##1 brownout_sleep_off_active[*3] ##1
    !brownout_sleep_off_active)
    else $error("sleep-off bit timing wrong");
  a_brownout_sleep_off_locked: assert property (@(posedge clock) disable iff (rst)
    (win_q == 3'h0 && dly_q == 3'h0 && hold_q == 3'h0 && !wr_en) |=> !brownout_sleep_off_active)
    else $error("sleep-off bit set without unlock");
endmodule

// *** design/spmc_top.sv ***
// Sleep mode and power management controller.
`timescale 1ns/10ps
module spmc_top
  import spmc_pkg::*;
#(
  parameter int START_UP_CYC = 16,
  parameter int BOD_WAKE_CYC = SPMC_BOD_WAKE_CYC,
  parameter int NPER = SPMC_NPER
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic sleep_enable_bit,
  input wire logic [2:0] sleep_mode_select,
  input wire logic sleep_instr,
  input wire logic core_ctrl_wr,
  input wire logic [7:0] core_ctrl_wdata,
  input wire logic ext_crystal_sel,
  input wire logic timer2_async,
  input wire logic timer2_sync,
  input wire logic adc_enabled,
  input wire logic status_reg_global_irq,
  input wire logic [1:0] timer2_irq_mask,
  input wire logic [1:0] timer2_event,
  input wire logic irq_any_enabled,
  input wire logic wake_adc_done,
  input wire logic wake_wdt,
  input wire logic wake_twi_match,
  input wire logic wake_spm_ready,
  input wire logic wake_ext_level,
  input wire logic wake_pin_change,
  input wire logic reset_req,
  input wire logic [NPER-1:0] power_reduction_reg,
  output logic clk_cpu_en,
  output logic clk_flash_en,
  output logic clk_io_en,
  output logic clk_adc_en,
  output logic clk_async_en,
  output logic main_osc_en,
  output logic timer_osc_en,
  output logic timer2_sync_clk_en,
  output logic [NPER-1:0] periph_clk_en,
  output logic adc_start,
  output logic brownout_detector_en,
  output logic [7:0] core_control_reg,
  output logic core_halt,
  output logic irq_service,
  output logic resume_reset_vector,
  output logic asleep
);
  spmc_state_e st_q, st_d;
  spmc_mode_e mode_q, mode_d;
  logic [SPMC_CNT_W-1:0] cnt_q, cnt_d;
  logic bod_off_q, bod_off_d;
  logic by_irq_q, by_irq_d;
  logic by_rst_q, by_rst_d;
  logic adc_start_q, adc_start_d;
  logic irq_service_q, irq_service_d;
  logic rstvec_q, rstvec_d;
  logic brownout_sleep_off_active;
  logic brownout_sleep_unlock_q;
  logic wake_any;
  logic wake_irq;
  logic t2_wake;

  spmc_brownout_sleep_off_seq i_spmc_brownout_sleep_off_seq (
    .clock(clock),
    .rst(rst),
    .wr_en(core_ctrl_wr),
    .wr_brownout_sleep_off(core_ctrl_wdata[SPMC_BROWNOUT_SLEEP_OFF_BIT]),
    .wr_brownout_sleep_unlock(core_ctrl_wdata[SPMC_BROWNOUT_SLEEP_UNLOCK_BIT]),
    .brownout_sleep_off_active(brownout_sleep_off_active),
    .brownout_sleep_unlock_q(brownout_sleep_unlock_q)
  );

  // ---------------------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------------------
  function automatic logic mode_deep(input spmc_mode_e m);
    mode_deep = (m == SPMC_PDOWN) || (m == SPMC_PSAVE) || (m == SPMC_STBY) || (m == SPMC_XSTBY);
  endfunction

  function automatic logic mode_t2(input spmc_mode_e m);
    mode_t2 = (m == SPMC_PSAVE) || (m == SPMC_XSTBY);
  endfunction

  function automatic logic [SPMC_CNT_W-1:0] wake_len(input spmc_mode_e m, input logic bod_off);
    logic [SPMC_CNT_W-1:0] base;
    base = SPMC_CNT_W'(START_UP_CYC);
    if ((m == SPMC_STBY) || (m == SPMC_XSTBY))
      base = SPMC_CNT_W'(SPMC_STBY_WAKE);
    else if ((m == SPMC_IDLE) || (m == SPMC_NOISE))
      base = SPMC_CNT_W'(1);
    if (bod_off && base < SPMC_CNT_W'(BOD_WAKE_CYC))
      base = SPMC_CNT_W'(BOD_WAKE_CYC);
    wake_len = base;
  endfunction

  // ---------------------------------------------------------------------------
  // Wake qualification
  // ---------------------------------------------------------------------------
  assign t2_wake = status_reg_global_irq && |(timer2_irq_mask & timer2_event);

  always_comb
  begin
    wake_any = 1'b0;
    wake_irq = 1'b0;
    unique case (mode_q)
      SPMC_IDLE:
      begin
        wake_irq = irq_any_enabled | wake_adc_done | wake_wdt | wake_twi_match | t2_wake | wake_spm_ready |
          wake_ext_level | wake_pin_change;
        wake_any = wake_irq;
      end
      SPMC_NOISE:
      begin
        wake_irq = wake_adc_done | wake_wdt | wake_twi_match | (timer2_async & t2_wake) | wake_spm_ready |
          wake_ext_level | wake_pin_change;
        wake_any = wake_irq;
      end
      SPMC_PDOWN, SPMC_STBY:
      begin
        wake_irq = wake_wdt | wake_twi_match | wake_ext_level | wake_pin_change;
        wake_any = wake_irq;
      end
      SPMC_PSAVE, SPMC_XSTBY:
      begin
        wake_irq = wake_wdt | wake_twi_match | wake_ext_level | wake_pin_change | t2_wake;
        wake_any = wake_irq;
      end
      SPMC_RSV4, SPMC_RSV5:
      begin
        wake_any = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Sleep sequencer
  // ---------------------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    mode_d = mode_q;
    cnt_d = cnt_q;
    bod_off_d = bod_off_q;
    by_irq_d = by_irq_q;
    by_rst_d = by_rst_q;
    adc_start_d = 1'b0;
    irq_service_d = 1'b0;
    rstvec_d = 1'b0;
    unique case (st_q)
      SPMC_RUN:
      begin
        if (sleep_instr && sleep_enable_bit && sleep_mode_select != SPMC_RSV4 &&
            sleep_mode_select != SPMC_RSV5)
        begin
          st_d = SPMC_SLEEP;
          mode_d = spmc_mode_e'(sleep_mode_select);
          bod_off_d = brownout_sleep_off_active && mode_deep(spmc_mode_e'(sleep_mode_select));
          adc_start_d = adc_enabled && (sleep_mode_select == SPMC_IDLE || sleep_mode_select == SPMC_NOISE);
        end
      end
      SPMC_SLEEP:
      begin
        if (reset_req || wake_any)
        begin
          st_d = SPMC_WAKE;
          by_rst_d = reset_req;
          by_irq_d = !reset_req && wake_irq;
          cnt_d = wake_len(mode_q, bod_off_q) + (wake_irq && !reset_req ? SPMC_CNT_W'(SPMC_IRQ_HALT) :
            SPMC_CNT_W'(0));
          bod_off_d = 1'b0;
        end
      end
      SPMC_WAKE:
      begin
        cnt_d = cnt_q - SPMC_CNT_W'(1);
        if (cnt_q == SPMC_CNT_W'(1))
        begin
          st_d = SPMC_RUN;
          irq_service_d = by_irq_q;
          rstvec_d = by_rst_q;
          by_irq_d = 1'b0;
          by_rst_d = 1'b0;
        end
      end
      default:
      begin
        st_d = SPMC_RUN;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      st_q <= SPMC_RUN;
      mode_q <= SPMC_IDLE;
      cnt_q <= '0;
      bod_off_q <= 1'b0;
      by_irq_q <= 1'b0;
      by_rst_q <= 1'b0;
      adc_start_q <= 1'b0;
      irq_service_q <= 1'b0;
      rstvec_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      mode_q <= mode_d;
      cnt_q <= cnt_d;
      bod_off_q <= bod_off_d;
      by_irq_q <= by_irq_d;
      by_rst_q <= by_rst_d;
      adc_start_q <= adc_start_d;
      irq_service_q <= irq_service_d;
      rstvec_q <= rstvec_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Clock and oscillator gating
  // ---------------------------------------------------------------------------
  // Only clocks, oscillators and the brown-out detector are gated; storage is never reset by sleep, so register file and RAM keep contents.
  logic slp;
  assign slp = (st_q == SPMC_SLEEP);
  assign asleep = slp;
  assign core_halt = (st_q != SPMC_RUN);
  assign clk_cpu_en = !slp;
  assign clk_flash_en = !slp;
  assign clk_io_en = !slp || (mode_q == SPMC_IDLE);
  assign clk_adc_en = !slp || (mode_q == SPMC_IDLE) || (mode_q == SPMC_NOISE);
  assign clk_async_en = !slp || (mode_q == SPMC_IDLE) || (mode_q == SPMC_NOISE) ||
    (mode_t2(mode_q) && timer2_async);
  assign main_osc_en = !slp || (mode_q == SPMC_IDLE) || (mode_q == SPMC_NOISE) ||
    ((mode_q == SPMC_STBY || mode_q == SPMC_XSTBY) && ext_crystal_sel) ||
    (mode_q == SPMC_PSAVE && timer2_sync);
  assign timer_osc_en = timer2_async && (!slp || mode_q == SPMC_IDLE || mode_q == SPMC_NOISE || mode_t2(mode_q));
  assign timer2_sync_clk_en = slp && mode_t2(mode_q) && timer2_sync;
  assign brownout_detector_en = !bod_off_q;

  genvar gi;
  generate
    for (gi = 0; gi < NPER; gi++)
    begin : g_per
      assign periph_clk_en[gi] = !power_reduction_reg[gi] && clk_io_en;
    end
  endgenerate

  always_comb
  begin
    core_control_reg = SPMC_CORE_CTRL_RESET;
    core_control_reg[SPMC_BROWNOUT_SLEEP_OFF_BIT] = brownout_sleep_off_active;
    core_control_reg[SPMC_BROWNOUT_SLEEP_UNLOCK_BIT] = brownout_sleep_unlock_q;
  end

  assign adc_start = adc_start_q;
  assign irq_service = irq_service_q;
  assign resume_reset_vector = rstvec_q;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  // Counts consecutive wake cycles so that wake lengths are checked without long repetitions.
  logic [SPMC_CNT_W-1:0] wake_cyc_q, wake_cyc_d;

  always_comb
  begin
    wake_cyc_d = '0;
    if (st_q == SPMC_WAKE)
      wake_cyc_d = wake_cyc_q + SPMC_CNT_W'(1);
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      wake_cyc_q <= '0;
    else
      wake_cyc_q <= wake_cyc_d;
  end

  a_sleep_needs_se: assert property (@(posedge clock) disable iff (rst)
    (st_q == SPMC_RUN && sleep_instr && !sleep_enable_bit) |=> st_q == SPMC_RUN)
    else $error("sleep entered without enable bit");
  a_rsv_noop: assert property (@(posedge clock) disable iff (rst)
    (st_q == SPMC_RUN && (sleep_mode_select == SPMC_RSV4 || sleep_mode_select == SPMC_RSV5)) |=> st_q == SPMC_RUN)
    else $error("reserved mode entered sleep");
  a_idle_clocks: assert property (@(posedge clock) disable iff (rst)
    (slp && mode_q == SPMC_IDLE) |-> (!clk_cpu_en && clk_io_en && clk_adc_en))
    else $error("idle clock gating wrong");
  a_noise_clocks: assert property (@(posedge clock) disable iff (rst)
    (slp && mode_q == SPMC_NOISE) |-> (!clk_io_en && clk_adc_en && !clk_flash_en))
    else $error("noise mode clock gating wrong");
  a_pdown_clocks: assert property (@(posedge clock) disable iff (rst)
    (slp && mode_q == SPMC_PDOWN) |-> (!main_osc_en && !clk_adc_en && !clk_async_en))
    else $error("power-down clock gating wrong");
  a_stby_wake: assert property (@(posedge clock) disable iff (rst)
    (slp && mode_q == SPMC_STBY && !bod_off_q && !reset_req && wake_any) |=>
    ##10 (!core_halt && wake_cyc_q == SPMC_CNT_W'(SPMC_STBY_WAKE + SPMC_IRQ_HALT)))
    else $error("standby wake length wrong");
  a_pdown_ignore: assert property (@(posedge clock) disable iff (rst)
    (slp && mode_q == SPMC_PDOWN && !reset_req && !wake_wdt && !wake_twi_match && !wake_ext_level &&
     !wake_pin_change) |=> slp)
    else $error("power-down woke on illegal source");
  a_reset_vector: assert property (@(posedge clock) disable iff (rst)
    (slp && reset_req) |=> (!slp ##[1:1000] resume_reset_vector))
    else $error("reset in sleep did not reach reset vector");
  a_bod_restore: assert property (@(posedge clock) disable iff (rst)
    (st_q == SPMC_WAKE) |-> brownout_detector_en)
    else $error("brown-out not restored on wake");
  a_adc_start: assert property (@(posedge clock) disable iff (rst)
    (st_q == SPMC_RUN && st_d == SPMC_SLEEP && adc_enabled && mode_d == SPMC_IDLE) |=> adc_start)
    else $error("conversion not started on idle entry");
  c_idle_wake: cover property (@(posedge clock) disable iff (rst) slp && mode_q == SPMC_IDLE ##1 st_q == SPMC_WAKE);
  c_psave_t2: cover property (@(posedge clock) disable iff (rst) slp && mode_q == SPMC_PSAVE && t2_wake);
  c_bod_off: cover property (@(posedge clock) disable iff (rst) slp && bod_off_q);
endmodule

// *** bench/spmc_core_model.sv ***
// Behavioural model of the processor core and of the wake event sources.
`timescale 1ns/10ps
module spmc_core_model
  import spmc_pkg::*;
(
  input wire logic clock,
  output logic sleep_enable_bit,
  output logic [2:0] sleep_mode_select,
  output logic sleep_instr,
  output logic [6:0] wake_src
);
  initial
  begin
    sleep_enable_bit = 1'b0;
    sleep_mode_select = 3'h0;
    sleep_instr = 1'b0;
    wake_src = 7'h00;
  end

  // The enable bit and mode stay as set; the sleep instruction lasts one cycle.
  task automatic sleep_req(input logic [2:0] m, input logic se);
    @(posedge clock);
    sleep_enable_bit <= se;
    sleep_mode_select <= m;
    sleep_instr <= 1'b1;
    @(posedge clock);
    sleep_instr <= 1'b0;
    #1;
  endtask

  // Bit 6 is the reset source, bits 5..0 the peripheral wake requests.
  task automatic raise(input logic [6:0] v);
    @(posedge clock);
    wake_src <= v;
  endtask
endmodule

// *** bench/spmc_top_tb.sv ***
// Self-checking testbench of the sleep and power management controller.
`timescale 1ns/10ps
module spmc_top_tb
  import spmc_pkg::*;
;
  localparam int SU = 12;
  localparam int BW = 20;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic sleep_enable_bit, sleep_instr, core_ctrl_wr, ext_crystal_sel, timer2_async, timer2_sync;
  logic adc_enabled, status_reg_global_irq, irq_any_enabled;
  logic [2:0] sleep_mode_select;
  logic [6:0] wake_src;
  logic [7:0] core_ctrl_wdata, power_reduction_reg, periph_clk_en, core_control_reg;
  logic [1:0] timer2_irq_mask, timer2_event;
  logic clk_cpu_en, clk_flash_en, clk_io_en, clk_adc_en, clk_async_en, main_osc_en, timer_osc_en;
  logic timer2_sync_clk_en, adc_start, brownout_detector_en, core_halt, irq_service;
  logic resume_reset_vector, asleep;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;

  spmc_core_model i_spmc_core_model (.clock, .sleep_enable_bit, .sleep_mode_select, .sleep_instr, .wake_src);

  spmc_top #(.START_UP_CYC(SU), .BOD_WAKE_CYC(BW), .NPER(8)) i_spmc_top (
    .clock, .rst, .sleep_enable_bit, .sleep_mode_select, .sleep_instr, .core_ctrl_wr, .core_ctrl_wdata,
    .ext_crystal_sel, .timer2_async, .timer2_sync, .adc_enabled, .status_reg_global_irq,
    .timer2_irq_mask, .timer2_event, .irq_any_enabled, .wake_adc_done(wake_src[0]),
    .wake_wdt(wake_src[1]), .wake_twi_match(wake_src[2]), .wake_spm_ready(wake_src[3]),
    .wake_ext_level(wake_src[4]), .wake_pin_change(wake_src[5]), .reset_req(wake_src[6]),
    .power_reduction_reg, .clk_cpu_en, .clk_flash_en, .clk_io_en, .clk_adc_en, .clk_async_en,
    .main_osc_en, .timer_osc_en, .timer2_sync_clk_en, .periph_clk_en, .adc_start,
    .brownout_detector_en, .core_control_reg, .core_halt, .irq_service, .resume_reset_vector, .asleep);

  always #50 clock = ~clock;

  task automatic finish_test();
    $display("Checks made %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      finish_test();
    end
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Counts the cycles the core stays halted after the wake edge, then checks the exit pulse.
  task automatic wait_halt(input int n, input logic rv);
    int c;
    c = 0;
    while (core_halt === 1'b1 && c < 2000)
    begin
      c++;
      @(posedge clock);
      #1;
    end
    chk("halt_cycles", c[15:0], n[15:0]);
    chk("irq_service", irq_service, !rv);
    chk("reset_vector", resume_reset_vector, rv);
  endtask

  task automatic wake(input logic [6:0] v, input int n);
    i_spmc_core_model.raise(v);
    i_spmc_core_model.raise(7'h00);
    #1;
    wait_halt(n, v[6]);
  endtask

  task automatic stay(input logic exp);
    repeat (3) @(posedge clock);
    #1;
    chk("asleep", asleep, exp);
  endtask

  task automatic wr(input logic [7:0] d);
    @(posedge clock);
    core_ctrl_wr <= 1'b1;
    core_ctrl_wdata <= d;
    @(posedge clock);
    core_ctrl_wr <= 1'b0;
    #1;
  endtask

  initial
  begin
    logic rsv, io, ok;
    core_ctrl_wr = 1'b0;
    core_ctrl_wdata = 8'h00;
    ext_crystal_sel = 1'b1;
    timer2_async = 1'b0;
    timer2_sync = 1'b0;
    adc_enabled = 1'b1;
    status_reg_global_irq = 1'b0;
    irq_any_enabled = 1'b0;
    timer2_irq_mask = 2'h0;
    timer2_event = 2'h0;
    power_reduction_reg = 8'h05;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    chk("reset_state", {core_control_reg, brownout_detector_en, clk_cpu_en, clk_io_en}, 11'h007);
    chk("periph_run", periph_clk_en, 8'hfa);
    for (int m = 0; m < 8; m++)
    begin
      i_spmc_core_model.sleep_req(m[2:0], 1'b1);
      rsv = (m == 4 || m == 5);
      io = (m == 0) || rsv;
      chk("asleep", asleep, !rsv);
      chk("adc_start", adc_start, m < 2);
      chk("clk_cpu_flash", {clk_cpu_en, clk_flash_en}, rsv ? 2'h3 : 2'h0);
      chk("clk_io", clk_io_en, io);
      chk("clk_adc", clk_adc_en, m < 2 || rsv);
      chk("main_osc", main_osc_en, m != 2 && m != 3);
      chk("periph_clk", periph_clk_en, io ? 8'hfa : 8'h00);
      if (!rsv)
        wake(7'h02, (m < 2 ? 1 : (m > 5 ? SPMC_STBY_WAKE : SU)) + SPMC_IRQ_HALT);
    end
    i_spmc_core_model.sleep_req(3'h0, 1'b0);
    chk("asleep_no_enable", asleep, 1'b0);
    for (int m = 1; m < 3; m++)
      for (int b = 0; b < 6; b++)
      begin
        i_spmc_core_model.sleep_req(m[2:0], 1'b1);
        i_spmc_core_model.raise(7'h01 << b);
        ok = (m == 1) || (b != 0 && b != 3);
        @(posedge clock);
        #1;
        chk("asleep_src", asleep, !ok);
        if (ok)
          wait_halt((m == 1 ? 1 : SU) + SPMC_IRQ_HALT, 1'b0);
        else
          wake(7'h02, SU + SPMC_IRQ_HALT);
        i_spmc_core_model.raise(7'h00);
      end
    i_spmc_core_model.sleep_req(3'h1, 1'b1);
    @(posedge clock) irq_any_enabled <= 1'b1;
    stay(1'b1);
    @(posedge clock) irq_any_enabled <= 1'b0;
    wake(7'h02, 1 + SPMC_IRQ_HALT);
    i_spmc_core_model.sleep_req(3'h0, 1'b1);
    @(posedge clock) irq_any_enabled <= 1'b1;
    @(posedge clock) irq_any_enabled <= 1'b0;
    #1;
    wait_halt(1 + SPMC_IRQ_HALT, 1'b0);
    @(posedge clock);
    timer2_async <= 1'b1;
    timer2_sync <= 1'b1;
    timer2_irq_mask <= 2'h1;
    i_spmc_core_model.sleep_req(3'h3, 1'b1);
    chk("psave_clocks", {timer_osc_en, main_osc_en, timer2_sync_clk_en, clk_async_en, clk_io_en}, 5'h1e);
    @(posedge clock) timer2_event <= 2'h1;
    stay(1'b1);
    @(posedge clock) status_reg_global_irq <= 1'b1;
    @(posedge clock);
    timer2_event <= 2'h0;
    status_reg_global_irq <= 1'b0;
    #1;
    wait_halt(SU + SPMC_IRQ_HALT, 1'b0);
    i_spmc_core_model.sleep_req(3'h2, 1'b1);
    wake(7'h40, SU);
    wr(8'h60);
    chk("unlock", core_control_reg[5], 1'b1);
    wr(8'h40);
    for (int i = 0; i < 7; i++)
    begin
      chk("sleep_off", core_control_reg[6], i >= 3 && i < 6);
      @(posedge clock);
      #1;
    end
    wr(8'h60);
    wr(8'h40);
    repeat (2) @(posedge clock);
    i_spmc_core_model.sleep_req(3'h2, 1'b1);
    chk("bod_off", brownout_detector_en, 1'b0);
    wake(7'h02, BW + SPMC_IRQ_HALT);
    chk("bod_on", brownout_detector_en, 1'b1);
    finish_test();
  end
endmodule
